// [tb_top.sv]
// self-checking bench for the wake event control block
// assumes the checker and far side model compile first
`timescale 1ns/10ps
`include "wake_pme_defs.svh"
module tb_top;
    logic        aclk = 0, aresetn = 0, bready = 0, rready = 0, lan_req = 0;
    logic        awvalid = 0, wvalid = 0, arvalid = 0, lan_src, wo, woe, irq, rdy, vphy, pin, rev;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rr, rresp;
    logic [3:0]  ev = 0; // digital, soft, port2, port1
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    int          err_count, n_checks, n_irq, n0;
    wake_event_pme_control #(.WAKE_PULSE_CYCLES(20), .VPHY_RESET_CYCLES(30)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .soft_reset(ev[2]), .digital_reset(ev[3]), .port1_energy_event(ev[0]),
        .port2_energy_event(ev[1]), .lan_wake_source(lan_src), .wake_event_out(wo),
        .wake_event_out_en(woe), .wake_interrupt_flag_set(irq), .device_ready(rdy),
        .device_ready_event(rev), .virtual_phy_reset(vphy));
    wake_far_side far (.aclk(aclk), .lan_req(lan_req), .wake_event_out(wo),
        .wake_event_out_en(woe), .lan_wake_source(lan_src), .pin_level(pin));
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    // counts wake flag pulses for the event scenarios
    always @(posedge aclk) if (irq) n_irq++;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one write of the control word, both halves offered together
    task automatic wr(input logic [31:0] v);
        @(posedge aclk);
        awaddr <= `PWC_OFFSET;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rr = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a = `PWC_OFFSET);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    // energy pulses stand for phys with phy_energy_powerdown already set
    task automatic pls(input int k);
        @(posedge aclk) ev[k] <= 1'b1;
        @(posedge aclk) ev[k] <= 1'b0;
        n0 = n0;
    endtask
    task automatic wrdy;
        repeat (2) @(negedge aclk);
        while (!rdy) @(negedge aclk);
        chk(rev, 1'b1);
    endtask
    task automatic t_basic;
        rd();
        chk(d, 32'h0);
        wrdy();
        rd();
        chk(d, 32'h1);
        chk(rdy, 1'b1);
        wr(32'h0000_3990);
        chk(rr, `RESP_OKAY);
        rd();
        chk(d, 32'h1);
        rd(12'h088);
        chk(rr, `RESP_SLVERR);
        $display("basic done");
    endtask
    task automatic t_lan;
        wr(32'h24e);
        n0 = n_irq;
        lan_req <= 1'b1;
        repeat (4) @(negedge aclk);
        chk(n_irq - n0, 1);
        chk({woe, pin}, 2'b11);
        wr(32'h26e);
        rd();
        chk(d, 32'h26f);
        lan_req <= 1'b0;
        repeat (3) @(negedge aclk);
        wr(32'h26e);
        rd();
        chk(d, 32'h24f);
        chk(pin, 1'b0);
        $display("lan done");
    endtask
    task automatic t_energy;
        wr(32'h4006);
        n0 = n_irq;
        pls(0);
        repeat (2) @(negedge aclk);
        chk(pin, 1'b0);
        repeat (25) @(negedge aclk);
        chk(pin, 1'b1);
        wr(32'h8000);
        pls(1);
        repeat (3) @(negedge aclk);
        chk({woe, pin}, 2'b01);
        chk(n_irq - n0, 2);
        $display("energy done");
    endtask
    task automatic t_vphy;
        wr(32'h400);
        rd();
        chk(d, 32'h401);
        wr(32'h0);
        rd();
        chk(d, 32'h401);
        while (vphy) @(negedge aclk);
        rd();
        chk(d, 32'h1);
        $display("vphy done");
    endtask
    task automatic t_resets;
        wr(32'h246);
        pls(2);
        repeat (2) @(negedge aclk);
        chk(rdy, 1'b0);
        wrdy();
        rd();
        chk(d, 32'h45);
        pls(3);
        wrdy();
        rd();
        chk(d, 32'h1);
        $display("resets done");
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_basic();
        t_lan();
        t_energy();
        t_vphy();
        t_resets();
        end_sim();
    end
    // cuts a hang short well past the expected run length
    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        end_sim();
    end
endmodule

// [wake_cycle_timer.sv]
// one-shot down counter: start loads a length, busy while running
// assumes a single clock and synchronous active-low reset
`timescale 1ns/10ps
`include "wake_pme_defs.svh"

module wake_cycle_timer (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    start,  // load and run
    input  wire logic                    abort,  // stop without done
    input  wire logic [`TIMER_CNT_W-1:0] length, // cycles to run
    output      logic                    busy,
    output      logic                    done
);

    wake_pme_pkg::timer_state_s s;      // registered state
    wake_pme_pkg::timer_state_s next_s; // next state

    // count down, flag the last cycle
    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        if (abort) begin
            // abort wins over everything
            next_s.busy = 1'b0;
            next_s.cnt  = '0;
        end else if (start) begin
            // restart from the full length
            next_s.busy = 1'b1;
            next_s.cnt  = length;
        end else if (s.busy) begin
            if (s.cnt <= `TIMER_CNT_W'(1)) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                next_s.cnt  = '0;
            end else begin
                next_s.cnt = s.cnt - `TIMER_CNT_W'(1);
            end
        end
    end

    // register the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;
    assign done = s.done;

endmodule

// [wake_event_pme_control.sv]
// wake event routing, wake pin control and power_wake_control register
// assumes an AXI4-Lite master, event inputs synchronous to aclk
`timescale 1ns/10ps
`include "wake_pme_defs.svh"

module wake_event_pme_control #(
    // cycles of the single wake pulse
    parameter int WAKE_PULSE_CYCLES = `WAKE_PULSE_MS * `CLK_FREQ_KHZ,
    // cycles the virtual phy is held in reset
    parameter int VPHY_RESET_CYCLES = `VPHY_RESET_CYCLES,
    // cycles from reset release until the device is ready
    parameter int STABLE_CYCLES     = `STABLE_CYCLES
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite slave
    input  wire logic [`ADDR_W-1:0] s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output      logic               s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output      logic               s_axi_wready,
    output      logic [1:0]         s_axi_bresp,
    output      logic               s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [`ADDR_W-1:0] s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output      logic               s_axi_arready,
    output      logic [31:0]        s_axi_rdata,
    output      logic [1:0]         s_axi_rresp,
    output      logic               s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // device resets other than aresetn, one-cycle pulses
    input  wire logic               soft_reset,
    input  wire logic               digital_reset,
    // wake sources
    input  wire logic               port1_energy_event, // one-cycle pulse
    input  wire logic               port2_energy_event, // one-cycle pulse
    input  wire logic               lan_wake_source,    // level, held by host mac
    // wake pin, open-drain or push-pull
    output      logic               wake_event_out,
    output      logic               wake_event_out_en,
    // to interrupt status and hardware config logic
    output      logic               wake_interrupt_flag_set, // one-cycle pulse
    output      logic               device_ready,            // level
    output      logic               device_ready_event,      // one-cycle pulse
    output      logic               virtual_phy_reset        // level
);

    wake_pme_pkg::wake_state_s s;      // registered state
    wake_pme_pkg::wake_state_s next_s; // next state

    logic        pulse_start;  // new wake event, in either mode
    logic        pulse_abort;  // drop the running pulse
    logic        pulse_busy;   // wake pulse running
    logic        vphy_start;   // accepted write of the reset bit
    logic        vphy_busy;    // virtual phy in reset
    logic        vphy_done;    // virtual phy leaves reset
    logic        ready_start;  // begin stabilisation
    logic        ready_abort;  // restart stabilisation
    logic        ready_done;   // stabilisation over
    logic [31:0] readback;     // register view
    logic [31:0] byte_mask;    // write strobes per bit
    logic        wr_hit;       // write address decodes
    logic        rd_hit;       // read address decodes
    logic        lan_clear;    // write-one-to-clear of the status
    logic        lan_rise;     // new lan wake event
    logic        wake_cause;   // some enabled event still pending
    logic        wake_active;  // logical wake state of the pin
    logic        any_reset;    // soft or digital reset

    // 50 ms wake pulse
    wake_cycle_timer pulse_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (pulse_start),
        .abort   (pulse_abort),
        .length  (`TIMER_CNT_W'(WAKE_PULSE_CYCLES)),
        .busy    (pulse_busy),
        .done    ()
    );

    // virtual phy reset length
    wake_cycle_timer vphy_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (vphy_start),
        .abort   (digital_reset),
        .length  (`TIMER_CNT_W'(VPHY_RESET_CYCLES)),
        .busy    (vphy_busy),
        .done    (vphy_done)
    );

    // stabilisation after any reset
    wake_cycle_timer ready_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (ready_start),
        .abort   (ready_abort),
        .length  (`TIMER_CNT_W'(STABLE_CYCLES)),
        .busy    (),
        .done    (ready_done)
    );

    // register view, reserved bits stay zero
    always_comb begin
        readback                      = '0;
        readback[`BIT_READY]          = s.ready;
        readback[`BIT_OUT_ENABLE]     = s.wake_out_enable;
        readback[`BIT_POLARITY]       = s.wake_out_polarity;
        readback[`BIT_PULSE_LEVEL]    = s.wake_out_pulse_level_select;
        readback[`BIT_LAN_STATUS]     = s.lan_wake_status;
        readback[`BIT_BUFFER_TYPE]    = s.wake_out_buffer_type;
        readback[`BIT_LAN_ENABLE]     = s.lan_wake_enable;
        readback[`BIT_VPHY_RESET]     = s.virtual_phy_soft_reset;
        readback[`BIT_P1_ENABLE]      = s.port1_energy_wake_enable;
        readback[`BIT_P2_ENABLE]      = s.port2_energy_wake_enable;
    end

    // address decode and strobe expansion
    always_comb begin
        byte_mask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
        if (s.awaddr == `PWC_OFFSET) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
        if (s_axi_araddr == `PWC_OFFSET) begin
            rd_hit = 1'b1;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // next state: bus, fields, events, pin
    always_comb begin
        next_s                  = s;
        next_s.wake_irq_set     = 1'b0;
        next_s.ready_event      = 1'b0;
        pulse_start             = 1'b0;
        vphy_start              = 1'b0;
        ready_start             = 1'b0;
        lan_clear               = 1'b0;
        any_reset               = soft_reset | digital_reset;
        ready_abort             = any_reset;

        // write response taken
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid   = 1'b0;
            next_s.wr_phase = wake_pme_pkg::wr_collect;
        end
        // write address and data taken in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.awaddr  = s_axi_awaddr;
            next_s.aw_held = 1'b1;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.wdata  = s_axi_wdata;
            next_s.wstrb  = s_axi_wstrb;
            next_s.w_held = 1'b1;
        end

        // both halves held: perform the write
        if (s.aw_held && s.w_held && s.wr_phase == wake_pme_pkg::wr_collect) begin
            next_s.aw_held  = 1'b0;
            next_s.w_held   = 1'b0;
            next_s.bvalid   = 1'b1;
            next_s.wr_phase = wake_pme_pkg::wr_respond;
            if (!wr_hit) begin
                // unmapped address
                next_s.bresp = `RESP_SLVERR;
            end else begin
                next_s.bresp = `RESP_OKAY;
                // writes before ready are dropped
                if (s.ready) begin
                    if (byte_mask[`BIT_OUT_ENABLE]) begin
                        next_s.wake_out_enable = s.wdata[`BIT_OUT_ENABLE];
                    end
                    if (byte_mask[`BIT_POLARITY]) begin
                        next_s.wake_out_polarity = s.wdata[`BIT_POLARITY];
                    end
                    if (byte_mask[`BIT_PULSE_LEVEL]) begin
                        next_s.wake_out_pulse_level_select = s.wdata[`BIT_PULSE_LEVEL];
                    end
                    if (byte_mask[`BIT_BUFFER_TYPE]) begin
                        next_s.wake_out_buffer_type = s.wdata[`BIT_BUFFER_TYPE];
                    end
                    if (byte_mask[`BIT_LAN_ENABLE]) begin
                        next_s.lan_wake_enable = s.wdata[`BIT_LAN_ENABLE];
                    end
                    if (byte_mask[`BIT_P1_ENABLE]) begin
                        next_s.port1_energy_wake_enable = s.wdata[`BIT_P1_ENABLE];
                    end
                    if (byte_mask[`BIT_P2_ENABLE]) begin
                        next_s.port2_energy_wake_enable = s.wdata[`BIT_P2_ENABLE];
                    end
                    // write one clears the status
                    lan_clear = byte_mask[`BIT_LAN_STATUS] & s.wdata[`BIT_LAN_STATUS];
                    // reset bit ignores writes while high
                    if (byte_mask[`BIT_VPHY_RESET] && s.wdata[`BIT_VPHY_RESET]
                        && !s.virtual_phy_soft_reset) begin
                        vphy_start                    = 1'b1;
                        next_s.virtual_phy_soft_reset = 1'b1;
                    end
                end
            end
        end
        // accept a new half only while the previous write is finished
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready  = !next_s.w_held && !next_s.bvalid;

        // read channel: one read at a time
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            if (rd_hit) begin
                next_s.rdata = readback;
                next_s.rresp = `RESP_OKAY;
            end else begin
                next_s.rdata = '0;
                next_s.rresp = `RESP_SLVERR;
            end
        end
        next_s.arready = !next_s.rvalid && !(s_axi_arvalid && s.arready);

        // virtual phy released: bit clears itself
        if (vphy_done) begin
            next_s.virtual_phy_soft_reset = 1'b0;
        end

        // lan wake status: source holds it, set wins over clear
        next_s.lan_src_q       = lan_wake_source;
        lan_rise               = lan_wake_source & ~s.lan_src_q;
        next_s.lan_wake_status = lan_wake_source | (s.lan_wake_status & ~lan_clear);

        // energy events kept for continuous mode until enable clears
        next_s.energy_latched[0] = next_s.port1_energy_wake_enable
            & (s.energy_latched[0] | port1_energy_event);
        next_s.energy_latched[1] = next_s.port2_energy_wake_enable
            & (s.energy_latched[1] | port2_energy_event);

        // interrupt flag, independent of the pin enable
        if ((s.port1_energy_wake_enable && port1_energy_event)
            || (s.port2_energy_wake_enable && port2_energy_event)) begin
            next_s.wake_irq_set = 1'b1;
        end
        if (s.lan_wake_enable && lan_rise) begin
            next_s.wake_irq_set = 1'b1;
        end

        // enabled event still pending; cleared status or enable drops it
        wake_cause = (next_s.lan_wake_status & next_s.lan_wake_enable)
            | (|next_s.energy_latched);
        // new event starts a fresh pulse
        pulse_start = next_s.wake_irq_set;
        pulse_abort = !wake_cause;

        // zero gives the single pulse, one the continuous level
        if (s.wake_out_pulse_level_select) begin
            wake_active = wake_cause;
        end else begin
            wake_active = wake_cause & (pulse_busy | pulse_start);
        end

        // pin drive
        if (!s.wake_out_enable) begin
            // pin disabled: released
            next_s.wake_event_out    = 1'b0;
            next_s.wake_event_out_en = 1'b0;
        end else if (!s.wake_out_buffer_type) begin
            // open-drain: pull low while active, polarity ignored
            next_s.wake_event_out    = 1'b0;
            next_s.wake_event_out_en = wake_active;
        end else begin
            // push-pull: always driven, polarity chooses the level
            next_s.wake_event_out    = s.wake_out_polarity ? wake_active : ~wake_active;
            next_s.wake_event_out_en = 1'b1;
        end

        // device ready after stabilisation
        if (s.ready_pending) begin
            ready_start          = 1'b1;
            next_s.ready_pending = 1'b0;
        end
        if (ready_done && !s.ready) begin
            next_s.ready       = 1'b1;
            next_s.ready_event = 1'b1;
        end

        // soft reset keeps buffer type and polarity
        if (any_reset) begin
            next_s.port2_energy_wake_enable    = `FIELD_RST;
            next_s.port1_energy_wake_enable    = `FIELD_RST;
            next_s.lan_wake_enable             = `FIELD_RST;
            next_s.wake_out_pulse_level_select = `FIELD_RST;
            next_s.wake_out_enable             = `FIELD_RST;
            next_s.lan_wake_status             = lan_wake_source;
            next_s.energy_latched              = '0;
            next_s.wake_event_out              = 1'b0;
            next_s.wake_event_out_en           = 1'b0;
            next_s.wake_irq_set                = 1'b0;
            next_s.ready                       = 1'b0;
            next_s.ready_event                 = 1'b0;
            next_s.ready_pending               = 1'b1;
            pulse_abort                        = 1'b1;
        end
        if (digital_reset) begin
            // full reset of the fields, including the kept ones
            next_s.wake_out_buffer_type   = `FIELD_RST;
            next_s.wake_out_polarity      = `FIELD_RST;
            next_s.virtual_phy_soft_reset = `FIELD_RST;
        end
    end

    // register the state; bus handshakes restart cleanly
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s               <= '0;
            s.ready_pending <= 1'b1;
            s.wr_phase      <= wake_pme_pkg::wr_collect;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready           = s.awready;
    assign s_axi_wready            = s.wready;
    assign s_axi_bvalid            = s.bvalid;
    assign s_axi_bresp             = s.bresp;
    assign s_axi_arready           = s.arready;
    assign s_axi_rvalid            = s.rvalid;
    assign s_axi_rdata             = s.rdata;
    assign s_axi_rresp             = s.rresp;
    assign wake_event_out          = s.wake_event_out;
    assign wake_event_out_en       = s.wake_event_out_en;
    assign wake_interrupt_flag_set = s.wake_irq_set;
    assign device_ready            = s.ready;
    assign device_ready_event      = s.ready_event;
    assign virtual_phy_reset       = s.virtual_phy_soft_reset;

endmodule

// [wake_far_side.sv]
// far side model: host mac wake source and the pulled-up wake pin
// assumes the bench requests lan wake frames through lan_req
`timescale 1ns/10ps
module wake_far_side (
    input  wire logic aclk,
    input  wire logic lan_req,             // bench asks for a wake frame
    input  wire logic wake_event_out,
    input  wire logic wake_event_out_en,
    output      logic lan_wake_source = 1'b0, // held until cleared in the mac
    output      logic pin_level            // resolved pin level
);
    // the mac keeps its source up until the bench clears it
    always @(posedge aclk) lan_wake_source <= lan_req;
    // a released pin floats to the pull-up level
    assign pin_level = wake_event_out_en ? wake_event_out : 1'b1;
endmodule

// [wake_pme_assertions.sv]
// port checker for the wake event control block
// assumes binding to wake_event_pme_control, one clock domain
`timescale 1ns/10ps
module wake_pme_assertions #(
    parameter int VPHY_RESET_CYCLES = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic soft_reset,
    input wire logic digital_reset,
    input wire logic wake_interrupt_flag_set,
    input wire logic device_ready,
    input wire logic virtual_phy_reset
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] vcnt; // cycles the virtual phy reset has stood high
    // counter feeds the bound on the virtual phy reset length
    always_ff @(posedge aclk) vcnt <= (virtual_phy_reset && aresetn) ? vcnt + 8'h01 : 8'h00;
    a_ready_clear: assert property ((soft_reset || digital_reset) |=> !device_ready)
        else $error("ready stayed high after a reset pulse");
    a_ready_hold: assert property (device_ready && !soft_reset && !digital_reset |=> device_ready)
        else $error("ready fell without a reset");
    a_irq_ready: assert property (wake_interrupt_flag_set |-> device_ready)
        else $error("wake flag raised before ready");
    a_irq_pulse: assert property (wake_interrupt_flag_set |=> !wake_interrupt_flag_set)
        else $error("wake flag set pulse too long");
    a_vphy_hold: assert property (disable iff (!aresetn || digital_reset)
        $rose(virtual_phy_reset) |-> virtual_phy_reset[*8]) else $error("vphy reset too short");
    a_vphy_bound: assert property (vcnt <= VPHY_RESET_CYCLES + 2)
        else $error("vphy reset did not clear itself");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    c_vphy: cover property ($rose(virtual_phy_reset));
    c_irq: cover property (wake_interrupt_flag_set);
    c_ready: cover property ($rose(device_ready));
endmodule
bind wake_event_pme_control wake_pme_assertions #(.VPHY_RESET_CYCLES(VPHY_RESET_CYCLES)) chk (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .soft_reset,
    .digital_reset, .wake_interrupt_flag_set, .device_ready, .virtual_phy_reset);

// [wake_pme_defs.svh]
// constants of the wake event and power management control block
// assumes inclusion by bare name from the package and design files
`ifndef WAKE_PME_DEFS_SVH
`define WAKE_PME_DEFS_SVH

// register map (byte address of the single control word)
`define PWC_OFFSET        12'h084
`define ADDR_W            12

// field positions inside power_wake_control
`define BIT_READY         0
`define BIT_OUT_ENABLE    1
`define BIT_POLARITY      2
`define BIT_PULSE_LEVEL   3
`define BIT_LAN_STATUS    5
`define BIT_BUFFER_TYPE   6
`define BIT_LAN_ENABLE    9
`define BIT_VPHY_RESET    10
`define BIT_P1_ENABLE     14
`define BIT_P2_ENABLE     15

// reset value of every control field
`define FIELD_RST         1'b0

// bus responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

// timing
`define CLK_FREQ_KHZ      40000
`define WAKE_PULSE_MS     50
`define TIMER_CNT_W       22
`define VPHY_RESET_CYCLES 16
`define STABLE_CYCLES     32

`endif

// [wake_pme_pkg.sv]
// types shared by the wake event control block and its timer
// assumes wake_pme_defs.svh sits in the include path
`include "wake_pme_defs.svh"

package wake_pme_pkg;

    // write channel progress
    typedef enum logic {wr_collect, wr_respond} wr_phase_e;

    // down counter state
    typedef struct packed {
        logic [`TIMER_CNT_W-1:0] cnt;  // cycles left
        logic                    busy; // counting
        logic                    done; // one-cycle end marker
    } timer_state_s;

    // complete state of the control block
    typedef struct packed {
        logic                port2_energy_wake_enable;
        logic                port1_energy_wake_enable;
        logic                virtual_phy_soft_reset;
        logic                lan_wake_enable;
        logic                wake_out_buffer_type;
        logic                wake_out_pulse_level_select;
        logic                wake_out_polarity;
        logic                wake_out_enable;
        logic                lan_wake_status;
        logic [1:0]          energy_latched; // per port, level mode memory
        logic                lan_src_q;      // source of previous cycle
        logic                wake_event_out;
        logic                wake_event_out_en;
        logic                wake_irq_set;
        logic                ready;
        logic                ready_event;
        logic                ready_pending;  // stabilisation timer to start
        wr_phase_e           wr_phase;
        logic                aw_held;
        logic                w_held;
        logic [`ADDR_W-1:0]  awaddr;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } wake_state_s;

endpackage
